/* core/bus_disconnect_pkg.sv */
// package: constants and carriers for the processor-side bus connection handshake
// assumes: used by bus_disconnect_handshake, sys_ctrl_model and the test bench
package bus_disconnect_pkg;
    localparam int          CMD_W              = 4;
    localparam int          ADDR_W             = 35;
    localparam int          DATA_W             = 32;
    localparam logic [3:0]  WRITE_LONGWORD_CMD = 4'h5;
    localparam logic [34:0] SPECIAL_CYCLE_BASE_ADDR = 35'h0_0000_0000;
    localparam logic [31:0] CONNECT_CYCLE_DATA = 32'h0004_0002;
    localparam logic [31:0] STOP_GRANT_CYCLE_DATA = 32'h0003_0002;
    localparam int          CLOCK_PERIOD_NS    = 25;
    localparam int          FWD_CLK_DELAY_PERIODS = 3;
    localparam int          FWD_CLK_DELAY_CYCLES = FWD_CLK_DELAY_PERIODS * 25 / CLOCK_PERIOD_NS;
    localparam int          SYNC_STAGES        = 3;

    typedef struct packed {
        logic [3:0]  cmd;
        logic [34:0] physical_address;
        logic [31:0] bus_data_word;
    } special_cycle_t;

    typedef struct packed {
        logic connect;
        logic forward_clock_reset;
        logic stop_clock_request_n;
        logic wake_interrupt;
    } link_in_t;
endpackage

/* core/pin_sync.sv */
// pin_sync: three-stage synchroniser with agreement filter for pin inputs
// assumes: inputs asynchronous to core_clk; ce freezes state
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int          WIDTH     = 4,
    parameter logic [3:0]  RESET_VAL = 4'h0
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    // pins in, filtered levels out
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] level_ff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= RESET_VAL[WIDTH-1:0];
            s2_ff   <= RESET_VAL[WIDTH-1:0];
            s3_ff   <= RESET_VAL[WIDTH-1:0];
        end else if (clk_en) begin
            meta_ff <= pin_in;
            s2_ff   <= meta_ff;
            s3_ff   <= s2_ff;
        end
    end

    // change accepted only when stages two and three agree
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            level_ff <= RESET_VAL[WIDTH-1:0];
        end else if (clk_en) begin
            level_ff <= (s2_ff & s3_ff) | (level_ff & (s2_ff | s3_ff));
        end
    end

    assign level_out = level_ff;
endmodule
`default_nettype wire

/* core/bus_disconnect_handshake.sv */
// bus_disconnect_handshake: processor end of the bus connect/disconnect protocol
// assumes: system controller and peripheral controller keep their own sequencing;
// special cycles leave through a one-deep request/accept port
// Functional notes
// R01: reconnect request is a write-longword special cycle with data 0004_0002
// R02: only the system starts a disconnect, after a stop-grant cycle
// R03: processor reconnects on interrupt or stop-clock release; system on probe need
// R04: disconnect occurs only when the system enables it
// R05: system drops connect only with no probes or transfers outstanding
// R06: connect sampled on clock edges; its drop makes the processor drop ready
// R07: system raises forward-clock reset after ready drops
// R08: system disconnects before forwarding stop-grant to the peripheral bus
// R09: wake before disconnect completes sends a connect cycle instead
// R10: system abandons disconnect on receiving a connect cycle
// R11: stop-clock request asserted makes the processor issue a stop-grant cycle
// R12: stop-clock release makes the processor raise ready
// R13: system raises connect after ready rises
// R14: system finally drops forward-clock reset
// R15: clocks slow while ready is low, full speed once ready rises
// R16: forwarded clocks restart three clock periods after forward-clock reset drops
// R17: system may also disconnect after a halt special cycle
// R18: disconnected processor reconnects on local wake or connect asserted
// R19: after a probe, connect drop makes a formerly disconnected processor disconnect again
// R20: stop-clock request active low; other lines active high, sampled on the clock
`timescale 1ns/1ps
`default_nettype none
module bus_disconnect_handshake #(
    parameter int DELAY_CYCLES = bus_disconnect_pkg::FWD_CLK_DELAY_CYCLES
) (
    // clock and reset
    input  wire logic                               core_clk,
    input  wire logic                               reset_n,
    input  wire logic                               clk_en,
    // pins from system and peripheral controllers
    input  wire logic                               connect,
    input  wire logic                               forward_clock_reset,
    input  wire logic                               stop_clock_request_n,
    input  wire logic                               wake_interrupt,
    input  wire logic                               halt_issued,
    // pins to system controller
    output logic                                    cpu_ready,
    // special cycle request port
    output var bus_disconnect_pkg::special_cycle_t  cycle_out,
    output logic                                    cycle_valid,
    input  wire logic                               cycle_accept,
    // core clock control
    output logic                                    clocks_slow,
    output logic                                    forward_clock_run
);
    typedef enum logic [6:0] {
        ST_CONNECTED  = 7'h01,
        ST_SEND_GRANT = 7'h02,
        ST_WAIT_DROP  = 7'h04,
        ST_SEND_CONN  = 7'h08,
        ST_DISCONN    = 7'h10,
        ST_RECONNECT  = 7'h20,
        ST_PROBE      = 7'h40
    } conn_state_t;

    function automatic bus_disconnect_pkg::special_cycle_t make_cycle(input logic [31:0] data);
        bus_disconnect_pkg::special_cycle_t c;
        c.cmd              = bus_disconnect_pkg::WRITE_LONGWORD_CMD;
        c.physical_address = bus_disconnect_pkg::SPECIAL_CYCLE_BASE_ADDR;
        c.bus_data_word    = data;
        return c;
    endfunction

    bus_disconnect_pkg::link_in_t       pin_lvl;
    conn_state_t                        state_ff;
    conn_state_t                        nxt_state;
    logic                               ready_ff;
    logic                               slow_ff;
    logic                               valid_ff;
    bus_disconnect_pkg::special_cycle_t cycle_ff;
    logic                               fcr_prev_ff;
    logic [3:0]                         fwd_cnt_ff;
    logic                               fwd_run_ff;
    logic                               wake;
    logic                               stop_req;
    logic                               sent;
    logic [1:0]                         async_lvl;
    logic [3:0]                         fwd_elapsed;

    // connect and forward-clock reset are launched on this clock, so sampled directly;
    // a synchroniser on them would push the restart past its fixed three periods
    pin_sync #(
        .WIDTH     (2),
        .RESET_VAL (4'h2)
    ) u_sync (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .pin_in    ({stop_clock_request_n, wake_interrupt}),
        .level_out (async_lvl)
    );

    assign pin_lvl  = {connect, forward_clock_reset, async_lvl}; // R20
    assign stop_req = !pin_lvl.stop_clock_request_n; // R20
    assign wake     = pin_lvl.wake_interrupt || !stop_req; // R03
    assign sent     = valid_ff && cycle_accept;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_CONNECTED: begin
                if (stop_req) begin
                    nxt_state = ST_SEND_GRANT; // R11
                end else if (!pin_lvl.connect && halt_issued) begin
                    nxt_state = ST_DISCONN; // R17
                end
            end
            ST_SEND_GRANT: begin
                if (sent) begin
                    nxt_state = ST_WAIT_DROP;
                end
            end
            ST_WAIT_DROP: begin
                if (wake) begin
                    nxt_state = ST_SEND_CONN; // R09
                end else if (!pin_lvl.connect) begin
                    nxt_state = ST_DISCONN; // R06
                end
            end
            ST_SEND_CONN: begin
                if (sent) begin
                    nxt_state = ST_CONNECTED;
                end
            end
            ST_DISCONN: begin
                if (!stop_req || pin_lvl.wake_interrupt) begin
                    nxt_state = ST_RECONNECT; // R18
                end else if (pin_lvl.connect) begin
                    nxt_state = ST_PROBE; // R18
                end
            end
            ST_RECONNECT: begin
                if (pin_lvl.connect && !pin_lvl.forward_clock_reset) begin
                    nxt_state = ST_CONNECTED;
                end
            end
            ST_PROBE: begin
                if (!pin_lvl.connect) begin
                    nxt_state = ST_DISCONN; // R19
                end else if (wake) begin
                    nxt_state = ST_RECONNECT;
                end
            end
            default: nxt_state = ST_CONNECTED;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_CONNECTED;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // ready and clock speed move together
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ready_ff <= 1'b1;
            slow_ff  <= 1'b0;
        end else if (clk_en) begin
            if (nxt_state == ST_DISCONN) begin
                ready_ff <= 1'b0; // R06
                slow_ff  <= 1'b1; // R15
            end else if (nxt_state == ST_RECONNECT || nxt_state == ST_PROBE) begin
                ready_ff <= 1'b1; // R12
                slow_ff  <= 1'b0; // R15
            end
        end
    end

    // request held until accepted
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            valid_ff <= 1'b0;
            cycle_ff <= '0;
        end else if (clk_en) begin
            if (sent) begin
                valid_ff <= 1'b0;
            end else if (!valid_ff && nxt_state == ST_SEND_GRANT && state_ff != ST_SEND_GRANT) begin
                valid_ff <= 1'b1;
                cycle_ff <= make_cycle(bus_disconnect_pkg::STOP_GRANT_CYCLE_DATA); // R11
            end else if (!valid_ff && nxt_state == ST_SEND_CONN && state_ff != ST_SEND_CONN) begin
                valid_ff <= 1'b1;
                cycle_ff <= make_cycle(bus_disconnect_pkg::CONNECT_CYCLE_DATA); // R01
            end
        end
    end

    // forwarded clock restart counter: periods elapsed since the reset line fell
    assign fwd_elapsed = fcr_prev_ff ? 4'h1 : fwd_cnt_ff + 4'h1;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fcr_prev_ff <= 1'b1;
            fwd_cnt_ff  <= 4'h0;
            fwd_run_ff  <= 1'b0;
        end else if (clk_en) begin
            fcr_prev_ff <= pin_lvl.forward_clock_reset;
            if (pin_lvl.forward_clock_reset) begin
                fwd_cnt_ff <= 4'h0;
                fwd_run_ff <= 1'b0;
            end else if (fcr_prev_ff || (fwd_cnt_ff != 4'h0 && !fwd_run_ff)) begin
                fwd_cnt_ff <= fwd_elapsed;
                if (fwd_elapsed == DELAY_CYCLES[3:0]) begin
                    fwd_run_ff <= 1'b1; // R16
                end
            end
        end
    end

    assign cpu_ready         = ready_ff;
    assign clocks_slow       = slow_ff;
    assign cycle_valid       = valid_ff;
    assign cycle_out         = cycle_ff;
    assign forward_clock_run = fwd_run_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence drop_seen_s;
        state_ff == ST_WAIT_DROP && !pin_lvl.connect && !wake && clk_en;
    endsequence

    ready_drop_a: assert property (drop_seen_s |=> !cpu_ready && clocks_slow) // R06
        else $error("ready not dropped after connect drop");
    connect_data_a: assert property (cycle_valid && state_ff == ST_SEND_CONN |->
        cycle_out.bus_data_word == 32'h0004_0002) // R01
        else $error("connect cycle data wrong");
    grant_issue_a: assert property (state_ff == ST_CONNECTED && stop_req && clk_en && !valid_ff |=>
        cycle_valid && cycle_out.bus_data_word == bus_disconnect_pkg::STOP_GRANT_CYCLE_DATA) // R11
        else $error("stop grant not issued");
    cancel_path_a: assert property (state_ff == ST_WAIT_DROP && wake && clk_en |=> state_ff == ST_SEND_CONN) // R09
        else $error("wake did not cancel disconnect");
    wake_ready_a: assert property (state_ff == ST_DISCONN && !stop_req && clk_en |=> cpu_ready) // R12
        else $error("ready not raised on wake");
    slow_tracks_a: assert property (clocks_slow == !cpu_ready) // R15
        else $error("clock speed and ready disagree");
    probe_redrop_a: assert property (state_ff == ST_PROBE && !pin_lvl.connect && clk_en |=>
        !cpu_ready && clocks_slow) // R19
        else $error("no redisconnect after probe");
    fwd_restart_a: assert property ($fell(pin_lvl.forward_clock_reset) && clk_en ##1 clk_en [*3] |->
        forward_clock_run) // R16
        else $error("forward clock not restarted");
    fwd_early_a: assert property ($fell(pin_lvl.forward_clock_reset) |-> !forward_clock_run) // R16
        else $error("forward clock ran early");
endmodule
`default_nettype wire

/* tb/sys_ctrl_model.sv */
// sys_ctrl_model: behavioural system controller facing the processor handshake
// assumes: shares core_clk; takes special cycles after a chosen accept delay
`timescale 1ns/1ps
`default_nettype none
module sys_ctrl_model (
    // clock and reset
    input  wire logic                               core_clk,
    input  wire logic                               reset_n,
    // scenario controls
    input  wire logic                               enable,
    input  wire logic                               probe,
    input  wire logic                               halt,
    input  wire logic [3:0]                         accept_delay,
    // processor side
    input  wire logic                               cpu_ready,
    input  wire bus_disconnect_pkg::special_cycle_t cycle_out,
    input  wire logic                               cycle_valid,
    output logic                                    cycle_accept,
    output logic                                    connect,
    output logic                                    forward_clock_reset
);
    typedef enum logic [2:0] {CONN, DROP, DISC, PROBE, RECON} sys_state_t;
    sys_state_t state_ff;
    logic [3:0] wait_ff;
    logic       took;
    logic       grant;
    assign cycle_accept = cycle_valid && (wait_ff >= accept_delay);
    assign took = cycle_valid && cycle_accept;
    assign grant = took && cycle_out.bus_data_word == bus_disconnect_pkg::STOP_GRANT_CYCLE_DATA;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            wait_ff <= 4'h0;
        else
            wait_ff <= (took || !cycle_valid) ? 4'h0 : wait_ff + 4'h1;
    end
    // no probes or transfers are ever outstanding here, so the drop is immediate
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= CONN;
            connect <= 1'b1;
            forward_clock_reset <= 1'b0;
        end else begin
            case (state_ff)
                CONN: if ((grant || halt) && enable) begin
                    connect <= 1'b0;
                    state_ff <= DROP;
                end
                DROP: if (took && cycle_out.bus_data_word == bus_disconnect_pkg::CONNECT_CYCLE_DATA) begin
                    connect <= 1'b1;
                    state_ff <= CONN;
                end else if (!cpu_ready) begin
                    forward_clock_reset <= 1'b1;
                    state_ff <= DISC;
                end
                DISC: if (probe) begin
                    connect <= 1'b1;
                    state_ff <= PROBE;
                end else if (cpu_ready) begin
                    connect <= 1'b1;
                    state_ff <= RECON;
                end
                PROBE: if (!probe) begin
                    connect <= 1'b0;
                    state_ff <= DROP;
                end
                default: begin
                    forward_clock_reset <= 1'b0;
                    state_ff <= CONN;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* tb/bus_disconnect_handshake_test.sv */
// bus_disconnect_handshake_test: self-checking bench for the processor connect handshake
// assumes: sys_ctrl_model plays the system controller, halt-driven disconnect included
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s exp=%h got=%h", nm, e, g); end end
module bus_disconnect_handshake_test;
    logic                               core_clk, reset_n, clk_en, connect, forward_clock_reset;
    logic                               stop_clock_request_n, wake_interrupt, cpu_ready, cycle_valid;
    logic                               cycle_accept, clocks_slow, forward_clock_run, enable, probe, halt_issued;
    logic [3:0]                         accept_delay;
    bus_disconnect_pkg::special_cycle_t cycle_out, exp_c;
    bus_disconnect_pkg::special_cycle_t exp_q[$];
    int                                 mismatches, n_tests, cyc, seed_val;

    bus_disconnect_handshake #(.DELAY_CYCLES(3)) bus_disconnect_handshake_inst (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .connect(connect),
        .forward_clock_reset(forward_clock_reset), .stop_clock_request_n(stop_clock_request_n),
        .wake_interrupt(wake_interrupt), .halt_issued(halt_issued), .cpu_ready(cpu_ready),
        .cycle_out(cycle_out), .cycle_valid(cycle_valid), .cycle_accept(cycle_accept),
        .clocks_slow(clocks_slow), .forward_clock_run(forward_clock_run));
    sys_ctrl_model sys_ctrl_model_inst (
        .core_clk(core_clk), .reset_n(reset_n), .enable(enable), .probe(probe), .halt(halt_issued),
        .accept_delay(accept_delay), .cpu_ready(cpu_ready), .cycle_out(cycle_out),
        .cycle_valid(cycle_valid), .cycle_accept(cycle_accept), .connect(connect),
        .forward_clock_reset(forward_clock_reset));

    function automatic bus_disconnect_pkg::special_cycle_t mk(input logic [31:0] d);
        mk = '{bus_disconnect_pkg::WRITE_LONGWORD_CMD, bus_disconnect_pkg::SPECIAL_CYCLE_BASE_ADDR, d};
    endfunction
    function automatic logic pick(input int w);
        pick = (w == 0) ? cpu_ready : forward_clock_run;
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    // the pin synchronisers blur exact latency, so waits are bounded, not fixed
    task automatic wait_for(input int w, input logic v, input string nm);
        int k;
        k = 0;
        while (pick(w) !== v && k < 60) begin
            step(1);
            k++;
        end
        `CHK(nm, v, pick(w))
    endtask
    task automatic drain();
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 60) begin
            step(1);
            k++;
        end
        `CHK("cycles_left", 0, exp_q.size())
    endtask
    task automatic end_of_test();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            end_of_test();
        end
    end
    always @(posedge core_clk) begin
        if (reset_n && cycle_valid && cycle_accept) begin
            if (exp_q.size() == 0)
                `CHK("cycle_extra", 1'b0, 1'b1)
            else begin
                exp_c = exp_q.pop_front();
                `CHK("cycle", exp_c, cycle_out)
            end
        end
    end

    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        stop_clock_request_n = 1'b1;
        wake_interrupt = 1'b0;
        enable = 1'b1;
        probe = 1'b0;
        halt_issued = 1'b0;
        accept_delay = 4'h0;
        mismatches = 0;
        n_tests = 0;
        cyc = 0;
        seed_val = $urandom(89707);
        step(2);
        `CHK("ready_rst", 1'b1, cpu_ready)
        `CHK("slow_rst", 1'b0, clocks_slow)
        `CHK("valid_rst", 1'b0, cycle_valid)
        `CHK("run_rst", 1'b0, forward_clock_run)
        reset_n = 1'b1;
        wait_for(1, 1'b1, "run_up");
        for (int i = 0; i < 2; i++) begin
            accept_delay = 4'($urandom_range(0, 7));
            exp_q.push_back(mk(bus_disconnect_pkg::STOP_GRANT_CYCLE_DATA));
            stop_clock_request_n = 1'b0;
            wait_for(0, 1'b0, "ready_drop");
            `CHK("slow_on", 1'b1, clocks_slow)
            wait_for(1, 1'b0, "run_stop");
            drain();
            if (i == 1) begin
                wake_interrupt = 1'b1;
                clk_en = 1'b0;
                step(8);
                `CHK("frozen", 1'b0, cpu_ready)
                clk_en = 1'b1;
            end
            stop_clock_request_n = 1'b1;
            wait_for(0, 1'b1, "ready_rise");
            `CHK("slow_off", 1'b0, clocks_slow)
            while (forward_clock_reset !== 1'b0)
                step(1);
            step(2);
            `CHK("run_held", 1'b0, forward_clock_run)
            step(1);
            `CHK("run_restart", 1'b1, forward_clock_run)
            wake_interrupt = 1'b0;
        end
        // disconnect disabled: grant goes out but the line never drops
        enable = 1'b0;
        accept_delay = 4'h0;
        exp_q.push_back(mk(bus_disconnect_pkg::STOP_GRANT_CYCLE_DATA));
        stop_clock_request_n = 1'b0;
        drain();
        step(12);
        `CHK("no_disc", 1'b1, cpu_ready)
        exp_q.push_back(mk(bus_disconnect_pkg::CONNECT_CYCLE_DATA));
        wake_interrupt = 1'b1;
        step(1);
        stop_clock_request_n = 1'b1;
        drain();
        wake_interrupt = 1'b0;
        step(12);
        `CHK("still_conn", 1'b1, cpu_ready)
        `CHK("conn_pin", 1'b1, connect)
        // stop released while the grant waits: connect cycle must cancel the drop
        enable = 1'b1;
        accept_delay = 4'hf;
        exp_q.push_back(mk(bus_disconnect_pkg::STOP_GRANT_CYCLE_DATA));
        exp_q.push_back(mk(bus_disconnect_pkg::CONNECT_CYCLE_DATA));
        stop_clock_request_n = 1'b0;
        while (cycle_valid !== 1'b1)
            step(1);
        stop_clock_request_n = 1'b1;
        drain();
        step(12);
        `CHK("cancel_ready", 1'b1, cpu_ready)
        `CHK("cancel_conn", 1'b1, connect)
        accept_delay = 4'h0;
        // halt-driven disconnect, then reconnect on the released stop line
        halt_issued = 1'b1;
        wait_for(0, 1'b0, "halt_drop");
        halt_issued = 1'b0;
        wait_for(1, 1'b0, "halt_fcr");
        wait_for(1, 1'b1, "halt_run");
        `CHK("halt_ready", 1'b1, cpu_ready)
        // probe while disconnected, then fall back to disconnected
        enable = 1'b1;
        exp_q.push_back(mk(bus_disconnect_pkg::STOP_GRANT_CYCLE_DATA));
        stop_clock_request_n = 1'b0;
        wait_for(0, 1'b0, "ready_pre");
        wait_for(1, 1'b0, "run_pre");
        probe = 1'b1;
        wait_for(0, 1'b1, "ready_probe");
        probe = 1'b0;
        wait_for(0, 1'b0, "ready_again");
        `CHK("slow_again", 1'b1, clocks_slow)
        stop_clock_request_n = 1'b1;
        wait_for(0, 1'b1, "ready_wake");
        wait_for(1, 1'b1, "run_wake");
        drain();
        end_of_test();
    end
endmodule
`default_nettype wire
